// *** src/oat_regs.sv ***
// Our own choice: the APB register port.
`timescale 1ns/1ns
module oat_regs #(
	parameter int unsigned AW = 12
) (
	// Clock and reset
	input  wire logic          CORE_CLK,
	input  wire logic          NRST,
	// APB slave
	input  wire logic          PSEL,
	input  wire logic          PENABLE,
	input  wire logic          PWRITE,
	input  wire logic [AW-1:0] PADDR,
	input  wire logic [31:0]   PWDATA,
	input  wire logic [3:0]    PSTRB,
	output logic      [31:0]   PRDATA,
	output logic               PREADY,
	output logic               PSLVERR,
	// Factory trim values, static after power-up
	input  wire logic [15:0]   TRIM_CORE1_INPUT_A,
	input  wire logic [15:0]   TRIM_CORE1_INPUT_B,
	input  wire logic [15:0]   TRIM_CORE2_INPUT_A,
	input  wire logic [15:0]   TRIM_CORE2_INPUT_B,
	// Corrections to the converter cores
	output logic      [11:0]   CORR_CORE1_INPUT_A,
	output logic      [11:0]   CORR_CORE1_INPUT_B,
	output logic      [11:0]   CORR_CORE2_INPUT_A,
	output logic      [11:0]   CORR_CORE2_INPUT_B
);

	if (AW < oat_pkg::ADDR_DECODE_W) begin : g_aw_check
		$error("oat_regs: address width below 12");
	end

	localparam int unsigned N = oat_pkg::N_TRIM;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Returns {hit, upper byte, register select}
	function automatic logic [3:0] oat_dec(input logic [AW-1:0] a);
		logic [9:0] i;
		logic [9:0] off;
		logic       hit;
		i   = a[oat_pkg::ADDR_DECODE_W-1:oat_pkg::IDX_LSB];
		off = i - oat_pkg::IDX_TRIM_CORE1_INPUT_A;
		hit = (a[1:0] == 2'h0) && ((a >> oat_pkg::ADDR_DECODE_W) == '0) &&
		      (i >= oat_pkg::IDX_TRIM_CORE1_INPUT_A) &&
		      (i <= oat_pkg::IDX_LAST);
		return {hit, ~i[0], off[2:1]};
	endfunction : oat_dec

	logic [3:0]  dec;
	logic        dec_hit;
	logic        dec_hi;
	logic [1:0]  dec_sel;
	logic        access;
	logic        wr_go;

	assign dec     = oat_dec(PADDR);
	assign dec_hit = dec[3];
	assign dec_hi  = dec[2];
	assign dec_sel = dec[1:0];
	assign access  = PSEL & PENABLE;
	// Commit at the edge where the master sees PREADY high
	assign wr_go   = access & PREADY & PWRITE & dec_hit & PSTRB[0];

	// ------------------------------------------------------------
	// Factory trim load
	// ------------------------------------------------------------
	// Trim pins are caught one edge after reset release, never by reset
	logic load_q;

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST)
			load_q <= 1'b1;
		else
			load_q <= 1'b0;
	end

	logic [15:0] trim_w [N];
	logic [15:0] val_w  [N];
	logic [11:0] corr_q [N];

	assign trim_w[oat_pkg::SEL_CORE1_INPUT_A] = TRIM_CORE1_INPUT_A;
	assign trim_w[oat_pkg::SEL_CORE1_INPUT_B] = TRIM_CORE1_INPUT_B;
	assign trim_w[oat_pkg::SEL_CORE2_INPUT_A] = TRIM_CORE2_INPUT_A;
	assign trim_w[oat_pkg::SEL_CORE2_INPUT_B] = TRIM_CORE2_INPUT_B;

	// ------------------------------------------------------------
	// Register bank and corrections
	// ------------------------------------------------------------
	for (genvar k = 0; k < N; k++) begin : g_trim
		oat_trim_reg #(
			.W (oat_pkg::TRIM_REG_W)
		) u_reg (
			.clk   (CORE_CLK),
			.rst_n (NRST),
			.load  (load_q),
			.trim  (trim_w[k]),
			.wr_hi (wr_go & dec_hi & (dec_sel == 2'(k))),
			.wr_lo (wr_go & ~dec_hi & (dec_sel == 2'(k))),
			.wbyte (PWDATA[7:0]),
			.val   (val_w[k])
		);

		always_ff @(posedge CORE_CLK or negedge NRST) begin
			if (!NRST)
				corr_q[k] <= '0;
			else
				corr_q[k] <= val_w[k][oat_pkg::CORR_W-1:0];
		end
	end

	assign CORR_CORE1_INPUT_A = corr_q[oat_pkg::SEL_CORE1_INPUT_A];
	assign CORR_CORE1_INPUT_B = corr_q[oat_pkg::SEL_CORE1_INPUT_B];
	assign CORR_CORE2_INPUT_A = corr_q[oat_pkg::SEL_CORE2_INPUT_A];
	assign CORR_CORE2_INPUT_B = corr_q[oat_pkg::SEL_CORE2_INPUT_B];

	// ------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------
	// One wait state buys a registered read path; held off during load
	logic        ready_q;
	logic        err_q;
	logic [31:0] rdata_q;
	logic [15:0] rsel;

	assign rsel = val_w[dec_sel];

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST)
			ready_q <= 1'b0;
		else
			ready_q <= access & ~ready_q & ~load_q;
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rdata_q <= 32'h0000_0000;
			err_q   <= 1'b0;
		end else if (access & ~ready_q & ~load_q) begin
			err_q <= ~dec_hit;
			if (dec_hit & ~PWRITE)
				rdata_q <= {24'h00_0000,
				            dec_hi ? rsel[15:8] : rsel[7:0]};
			else
				rdata_q <= 32'h0000_0000;
		end else begin
			err_q <= 1'b0;
		end
	end

	assign PREADY  = ready_q;
	assign PSLVERR = err_q;
	assign PRDATA  = rdata_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	trim_loaded_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		$fell(load_q) |-> (val_w[0] == $past(TRIM_CORE1_INPUT_A)) &&
		                  (val_w[3] == $past(TRIM_CORE2_INPUT_B)))
		else $error("trim not loaded after reset");

	corr_follow_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(wr_go && !dec_hi && dec_sel == 2'h1) |=> ##1
		(CORR_CORE1_INPUT_B[7:0] == $past(PWDATA[7:0], 2)))
		else $error("correction did not follow write");

	upper_byte_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(wr_go && dec_hi) |=>
		(val_w[$past(dec_sel)][15:8] == $past(PWDATA[7:0])))
		else $error("upper byte not at lower index");

	resv_write_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(wr_go && dec_hi && dec_sel == 2'h2) |=>
		(val_w[2][15:12] == $past(PWDATA[7:4])))
		else $error("reserved bits not writable");

	c1a_place_a: assert property (@(posedge CORE_CLK)
		disable iff (!NRST)
		(access && !ready_q && !load_q && !PWRITE &&
		 PADDR == AW'(12'h23c)) |=>
		(PRDATA[7:0] == $past(val_w[0][7:0])) && PREADY)
		else $error("core one first input misplaced");

	c1b_place_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(access && !ready_q && !load_q && !PWRITE &&
		 PADDR == AW'(12'h240)) |=>
		(PRDATA[7:0] == $past(val_w[1][15:8])))
		else $error("core one second input misplaced");

	c2a_place_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(access && !ready_q && !load_q && !PWRITE &&
		 PADDR == AW'(12'h24c)) |=>
		(PRDATA[7:0] == $past(val_w[2][7:0])))
		else $error("core two first input misplaced");

	c2b_place_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(access && !ready_q && !load_q && !PWRITE &&
		 PADDR == AW'(12'h250)) |=>
		(PRDATA[7:0] == $past(val_w[3][15:8])))
		else $error("core two second input misplaced");

	ready_pulse_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");

endmodule : oat_regs

// *** inc/oat_pkg.sv ***
package oat_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [9:0] IDX_TRIM_CORE1_INPUT_A = 10'h08e;
	localparam logic [9:0] IDX_TRIM_CORE1_INPUT_B = 10'h090;
	localparam logic [9:0] IDX_TRIM_CORE2_INPUT_A = 10'h092;
	localparam logic [9:0] IDX_TRIM_CORE2_INPUT_B = 10'h094;
	localparam logic [9:0] IDX_LAST               = 10'h095;
	localparam int unsigned IDX_LSB               = 2;
	localparam int unsigned ADDR_DECODE_W         = 12;

	// ------------------------------------------------------------
	// Register layout
	// ------------------------------------------------------------
	localparam int unsigned N_TRIM       = 4;
	localparam int unsigned TRIM_REG_W   = 16;
	localparam int unsigned CORR_W       = 12;
	localparam int unsigned CORR_LSB     = 0;
	localparam int unsigned RESV_LSB     = 12;
	localparam int unsigned BYTE_W       = 8;
	localparam logic [3:0]  RESV_RST     = 4'h0;
	localparam logic [15:0] TRIM_REG_RST = 16'h0000;

	// ------------------------------------------------------------
	// Register order in the bank
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_CORE1_INPUT_A = 2'h0;
	localparam logic [1:0] SEL_CORE1_INPUT_B = 2'h1;
	localparam logic [1:0] SEL_CORE2_INPUT_A = 2'h2;
	localparam logic [1:0] SEL_CORE2_INPUT_B = 2'h3;

endpackage : oat_pkg

// *** src/oat_trim_reg.sv ***
`timescale 1ns/1ns
module oat_trim_reg #(
	parameter int unsigned W = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Factory trim load
	input  wire logic         load,
	input  wire logic [W-1:0] trim,
	// Byte writes
	input  wire logic         wr_hi,
	input  wire logic         wr_lo,
	input  wire logic [7:0]   wbyte,
	// Stored value
	output logic      [W-1:0] val
);

	if (W != oat_pkg::TRIM_REG_W) begin : g_w_check
		$error("oat_trim_reg: width must be 16");
	end

	logic [W-1:0] val_q;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			val_q <= oat_pkg::TRIM_REG_RST;
		end else if (load) begin
			val_q <= trim;
		end else begin
			if (wr_hi)
				val_q[W-1:oat_pkg::BYTE_W] <= wbyte;
			if (wr_lo)
				val_q[oat_pkg::BYTE_W-1:0] <= wbyte;
		end
	end

	assign val = val_q;

endmodule : oat_trim_reg

// *** dv/oat_regs_tb.sv ***
`timescale 1ns/1ns
module oat_regs_tb;
	// ----------------------------------------
	// Stimulus and observation
	// ----------------------------------------
	logic        core_clk;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] trim [4];
	logic [11:0] corr [4];
	logic [9:0]  idx  [4];
	int          err_total;
	int          compares;

	oat_regs u_dut (
		.CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TRIM_CORE1_INPUT_A(trim[0]), .TRIM_CORE1_INPUT_B(trim[1]),
		.TRIM_CORE2_INPUT_A(trim[2]), .TRIM_CORE2_INPUT_B(trim[3]),
		.CORR_CORE1_INPUT_A(corr[0]), .CORR_CORE1_INPUT_B(corr[1]),
		.CORR_CORE2_INPUT_A(corr[2]), .CORR_CORE2_INPUT_B(corr[3])
	);

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Waits for the answer; only the watchdog ends a dead transfer
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [7:0] d, input logic [3:0] s,
			output logic [31:0] rd, output logic er);
		int n;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= {24'h000000, d};
		pstrb  <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1);
		// One wait state: answer at the second access-phase edge
		chk(32'(n), 32'h00000002);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [11:0] ba(input int r, input int lo);
		return {idx[r] + 10'(lo), 2'b00};
	endfunction : ba

	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 8'h00, 4'h0, rd, er);
		chk({rd[31:1], er}, {24'h000000, e[7:1], 1'b0});
		chk({31'h0, rd[0]}, {31'h0, e[0]});
	endtask : rdc

	task automatic wrc(input logic [11:0] a, input logic [7:0] d,
			input logic [3:0] s, input logic e);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, s, rd, er);
		chk({31'h0, er}, {31'h0, e});
	endtask : wrc

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_trim_view();
		for (int r = 0; r < 4; r++) begin
			rdc(ba(r, 0), trim[r][15:8]);
			rdc(ba(r, 1), trim[r][7:0]);
			chk({20'h0, corr[r]}, {20'h0, trim[r][11:0]});
		end
	endtask : t_trim_view

	// Upper halves first, so each half is seen to move on its own
	task automatic t_write_all();
		logic [15:0] v;
		for (int r = 0; r < 4; r++) begin
			v = 16'hf05a + 16'(r * 16'h0321);
			wrc(ba(r, 0), v[15:8], 4'h1, 1'b0);
			rdc(ba(r, 1), trim[r][7:0]);
			wrc(ba(r, 1), v[7:0], 4'hf, 1'b0);
			rdc(ba(r, 0), v[15:8]);
			rdc(ba(r, 1), v[7:0]);
			repeat (2) @(posedge core_clk);
			chk({20'h0, corr[r]}, {20'h0, v[11:0]});
		end
	endtask : t_write_all

	task automatic t_refused();
		logic [15:0] v;
		v = 16'hf05a;
		wrc(12'h000, 8'h33, 4'h1, 1'b1);
		wrc(ba(0, 0) | 12'h001, 8'h33, 4'h1, 1'b1);
		wrc({oat_pkg::IDX_LAST + 10'h001, 2'b00}, 8'h33, 4'h1, 1'b1);
		wrc(ba(0, 1), 8'h33, 4'h2, 1'b0);
		rdc(ba(0, 0), v[15:8]);
		rdc(ba(0, 1), v[7:0]);
	endtask : t_refused

	// Second reset mid-run must bring the factory trim back
	task automatic t_rereset();
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk({20'h0, corr[2]}, 32'h00000000);
		nrst <= 1'b1;
		t_trim_view();
	endtask : t_rereset

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic summarize();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		#2000000;
		err_total++;
		summarize();
	end

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
		err_total = 0;
		compares = 0;
		trim = '{16'h0123, 16'h0456, 16'h0789, 16'h0abc};
		idx = '{oat_pkg::IDX_TRIM_CORE1_INPUT_A, oat_pkg::IDX_TRIM_CORE1_INPUT_B,
			oat_pkg::IDX_TRIM_CORE2_INPUT_A, oat_pkg::IDX_TRIM_CORE2_INPUT_B};
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		t_trim_view();
		t_write_all();
		t_refused();
		t_rereset();
		summarize();
	end
endmodule : oat_regs_tb
